// ---- pkg/ssfs_cfg.svh ----
`ifndef SSFS_CFG_SVH
`define SSFS_CFG_SVH

// register port offsets
`define SSFS_ADDR_CTRL 8'h00
`define SSFS_ADDR_DIV 8'h04
`define SSFS_ADDR_STAT 8'h08

// control register fields
`define SSFS_CTRL_EN 0
`define SSFS_CTRL_SLAVE 1
`define SSFS_CTRL_FMT_LO 2
`define SSFS_CTRL_FMT_HI 3
`define SSFS_CTRL_POL 4
`define SSFS_CTRL_PHA 5
`define SSFS_CTRL_SIZE_LO 8
`define SSFS_CTRL_SIZE_HI 11

// reset values
`define SSFS_CTRL_RESET 16'h0700
`define SSFS_DIV_RESET 8'h04
`define SSFS_PINS_RESET 6'h08
// packed config after reset: master, spi, pol0, pha0, 8 bit words
`define SSFS_CFG_RESET 9'h007

// word size limits, encoded as bits minus one
`define SSFS_SIZE_MIN 4'h3

// command/response frame timing, in half bit periods
`define SSFS_CMD_LAST_SHIFT 6'h0f
`define SSFS_CMD_REPLY_EV 6'h12
`define SSFS_CMD_TAIL 6'h11

`endif

// ---- pkg/ssfs_pkg.sv ----
package ssfs_pkg;

   typedef enum logic [1:0] {
      FMT_SPI = 2'b00,
      FMT_CMD = 2'b01
   } ssfs_fmt_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MASTER = 2'b01,
      ST_SLAVE = 2'b10
   } ssfs_state_type;

   typedef struct packed {
      logic slave;
      logic [1:0] fmt;
      logic clock_idle_polarity;
      logic capture_edge_phase;
      logic [3:0] size;
   } ssfs_cfg_type;

   typedef struct packed {
      logic clk;
      logic clk_oe;
      logic fss;
      logic fss_oe;
      logic out;
      logic out_oe;
   } ssfs_pins_type;

endpackage

// ---- logic/ssfs_sync.sv ----
`timescale 1ns/100ps
module ssfs_sync
   #(parameter int WIDTH = 3)
   (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
   );

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         logic meta_q;
         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               meta_q <= 1'b0;
               q[i] <= 1'b0;
            end
            else
            begin
               meta_q <= d[i];
               q[i] <= meta_q;
            end
         end
      end
   endgenerate

endmodule // ssfs_sync

// ---- logic/ssfs_shift.sv ----
`timescale 1ns/100ps
module ssfs_shift
   import ssfs_pkg::*;
   (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // transmit side, msb aligned to bit 15
   input wire logic load,
   input wire logic [15:0] load_word,
   input wire logic shift_tx,
   output logic tx_msb,
   output logic tx_next,
   // receive side, filled from bit 0
   input wire logic cap,
   input wire logic cap_bit,
   output logic [15:0] rx_word,
   output logic [15:0] rx_next
   );

   logic [15:0] tx_q;
   logic [15:0] rx_q;

   assign tx_msb = tx_q[15];
   assign tx_next = tx_q[14];
   assign rx_word = rx_q;
   assign rx_next = {rx_q[14:0], cap_bit};

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         tx_q <= 16'h0000;
      else if (load)
         tx_q <= load_word;
      else if (shift_tx)
         tx_q <= {tx_q[14:0], 1'b0};
   end

   // load clears the receiver; a slave word it ends is taken from rx_next, a master word from rx_word
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rx_q <= 16'h0000;
      else if (load)
         rx_q <= 16'h0000;
      else if (cap)
         rx_q <= rx_next;
   end

endmodule // ssfs_shift

// ---- logic/ssfs_seq.sv ----
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`include "ssfs_cfg.svh"
module ssfs_seq
   import ssfs_pkg::*;
   (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata_q,
   // fifo side
   input wire logic tx_valid,
   input wire logic [15:0] tx_data,
   output logic tx_pop_q,
   output logic rx_write_q,
   output logic [15:0] rx_data_q,
   // serial pins
   input wire logic bit_clock_line_i,
   input wire logic frame_select_line_i,
   input wire logic serial_in_line_i,
   output ssfs_pins_type pins_q
   );

   logic [15:0] ctrl_q;
   logic [15:0] ctrl_d;
   logic [7:0] div_q;
   ssfs_cfg_type cfg_q;
   ssfs_cfg_type cfg_d;
   ssfs_state_type state_q;
   ssfs_state_type state_d;
   ssfs_pins_type pins_d;
   logic [7:0] hc_q;
   logic [5:0] t_q;
   logic [5:0] tc_q;
   logic [4:0] bc_q;
   logic first_q;
   logic [2:0] sync_q;
   logic sclk_p_q;
   logic fss_p_q;
   logic tx_msb;
   logic tx_next;
   logic [15:0] rx_word;
   logic [15:0] rx_next;

   // register port decode
   wire wr_ctrl = reg_wr && (reg_addr == `SSFS_ADDR_CTRL);
   wire wr_div = reg_wr && (reg_addr == `SSFS_ADDR_DIV);
   wire en = ctrl_q[`SSFS_CTRL_EN];
   assign ctrl_d = wr_ctrl ? reg_wdata : ctrl_q;
   wire [1:0] fmt_w = ctrl_d[`SSFS_CTRL_FMT_HI:`SSFS_CTRL_FMT_LO];
   wire cmd_w = (fmt_w == FMT_CMD);
   wire [3:0] size_w = ctrl_d[`SSFS_CTRL_SIZE_HI:`SSFS_CTRL_SIZE_LO];
   wire [3:0] size_c = (size_w < `SSFS_SIZE_MIN) ? `SSFS_SIZE_MIN : size_w;
   // command format is master only, polarity zero
   assign cfg_d = {ctrl_d[`SSFS_CTRL_SLAVE] && !cmd_w, (cmd_w ? FMT_CMD : FMT_SPI),
                   ctrl_d[`SSFS_CTRL_POL] && !cmd_w, ctrl_d[`SSFS_CTRL_PHA] && !cmd_w,
                   size_c};
   wire [15:0] stat_w = {13'h0000, state_q == ST_SLAVE, pins_q.fss, state_q != ST_IDLE};
   wire [15:0] rd_mux = (reg_addr == `SSFS_ADDR_CTRL) ? ctrl_q :
                        (reg_addr == `SSFS_ADDR_DIV) ? {8'h00, div_q} :
                        (reg_addr == `SSFS_ADDR_STAT) ? stat_w : 16'h0000;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_q <= `SSFS_CTRL_RESET;
         div_q <= `SSFS_DIV_RESET;
         reg_rdata_q <= 16'h0000;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         div_q <= wr_div ? reg_wdata[7:0] : div_q;
         reg_rdata_q <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // config only follows the control register while disabled
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         cfg_q <= `SSFS_CFG_RESET;
      else if (!en)
         cfg_q <= cfg_d;
   end

   // pins from outside pass two flops first
   ssfs_sync #(.WIDTH(3)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d({bit_clock_line_i, frame_select_line_i, serial_in_line_i}),
      .q(sync_q)
   );
   wire sclk_s = sync_q[2];
   wire fss_s = sync_q[1];
   wire in_s = sync_q[0];

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sclk_p_q <= 1'b0;
         fss_p_q <= 1'b1;
      end
      else
      begin
         sclk_p_q <= sclk_s;
         fss_p_q <= fss_s;
      end
   end

   // common terms
   wire is_cmd = (cfg_q.fmt == FMT_CMD);
   wire master = !cfg_q.slave || is_cmd;
   wire pol = cfg_q.clock_idle_polarity;
   wire pha = cfg_q.capture_edge_phase;
   wire [4:0] nbits = {1'b0, cfg_q.size} + 5'h01;
   wire [5:0] n2 = {nbits, 1'b0};
   wire more = en && tx_valid;

   // master: one tick per half bit period, t numbers the ticks of a word
   wire [7:0] div_m1 = (div_q == 8'h00) ? 8'h00 : div_q - 8'h01;
   wire tick = (state_q == ST_MASTER) && (hc_q == div_m1);
   wire spi_tog = pha ? (t_q < n2) : ((t_q != 6'h00) && (t_q <= n2));
   wire spi_cap = t_q[0] && (t_q < n2);
   wire spi_shift = !t_q[0] && (t_q != 6'h00) && (t_q < n2);
   wire spi_cont = pha && (t_q == n2) && more;
   wire spi_end = (t_q == n2 + 6'h01);
   wire [5:0] cmd_last = n2 + `SSFS_CMD_TAIL;
   wire cmd_tog = (t_q <= cmd_last);
   wire cmd_cap = !t_q[0] && (t_q >= `SSFS_CMD_REPLY_EV) && (t_q < cmd_last);
   wire cmd_shift = t_q[0] && (t_q <= `SSFS_CMD_LAST_SHIFT);
   wire cmd_cont = (t_q == cmd_last) && more;
   wire cmd_end = (t_q == cmd_last + 6'h01);
   wire m_tog = tick && (is_cmd ? cmd_tog : spi_tog);
   wire m_cap = tick && (is_cmd ? cmd_cap : spi_cap);
   wire m_shift = tick && (is_cmd ? cmd_shift : spi_shift);
   wire m_pres = tick && !is_cmd && (t_q == 6'h00);
   wire m_cont = tick && (is_cmd ? cmd_cont : spi_cont);
   wire m_end = tick && (is_cmd ? cmd_end : spi_end);
   wire m_start = (state_q == ST_IDLE) && en && master && tx_valid;

   // slave: edges of the sampled link clock
   wire s_lead = (sclk_p_q == pol) && (sclk_s != pol);
   wire s_trail = (sclk_p_q != pol) && (sclk_s == pol);
   wire s_fss_fall = fss_p_q && !fss_s;
   wire s_fss_rise = !fss_p_q && fss_s;
   wire s_act = (state_q == ST_SLAVE);
   wire s_cap = s_act && (pha ? s_trail : s_lead);
   wire s_chg = s_act && (pha ? s_lead : s_trail);
   wire s_done = s_cap && ((bc_q + 5'h01) == nbits);
   wire s_start = (state_q == ST_IDLE) && en && !master && s_fss_fall;

   // shifter control; an empty fifo in slave mode sends zeros
   wire load = m_start || m_cont || s_start || (s_done && pha);
   wire [15:0] spi_word = tx_data << (4'hf - cfg_q.size);
   wire [15:0] load_word = !tx_valid ? 16'h0000 :
                           is_cmd ? {tx_data[7:0], 8'h00} : spi_word;
   wire shift_tx = m_shift || (s_chg && !first_q);
   wire cap = m_cap || s_cap;

   ssfs_shift u_shift (
      .clk(clk),
      .rst_b(rst_b),
      .load(load),
      .load_word(load_word),
      .shift_tx(shift_tx),
      .tx_msb(tx_msb),
      .tx_next(tx_next),
      .cap(cap),
      .cap_bit(in_s),
      .rx_word(rx_word),
      .rx_next(rx_next)
   );

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:
            if (m_start)
               state_d = ST_MASTER;
            else if (s_start)
               state_d = ST_SLAVE;
         ST_MASTER:
            if (m_end)
               state_d = ST_IDLE;
         ST_SLAVE:
            if (s_fss_rise)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
      if (!en)
         state_d = ST_IDLE;
   end

   // pin drive
   wire run_m = (state_q == ST_MASTER) && en;
   wire clk_d = !run_m ? pol : m_end ? pol : (m_tog ? !pins_q.clk : pins_q.clk);
   wire fss_d = !en ? 1'b1 : m_start ? 1'b0 : (m_end ? 1'b1 : pins_q.fss);
   // command and slave words show their msb at load; spi master waits a half period
   wire out_d = (!en || m_end || s_fss_rise) ? 1'b0 :
                (load && (is_cmd || !master)) ? load_word[15] :
                m_pres ? tx_msb :
                shift_tx ? tx_next : pins_q.out;
   assign pins_d = {clk_d, en && master, fss_d, en && master, out_d,
                    en && (master || state_d == ST_SLAVE)};

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= ST_IDLE;
         pins_q <= `SSFS_PINS_RESET;
      end
      else
      begin
         state_q <= state_d;
         pins_q <= pins_d;
      end
   end

   // master counters; tc only counts clock toggles of the current word
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hc_q <= 8'h00;
         t_q <= 6'h00;
         tc_q <= 6'h00;
      end
      else
      begin
         hc_q <= (state_q != ST_MASTER || tick) ? 8'h00 : hc_q + 8'h01;
         if (m_start || m_cont)
            t_q <= 6'h00;
         else if (tick)
            t_q <= t_q + 6'h01;
         if (m_start || m_cont)
            tc_q <= 6'h00;
         else if (m_tog)
            tc_q <= tc_q + 6'h01;
      end
   end

   // slave bit counter; first_q skips a change edge already shown at load
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bc_q <= 5'h00;
         first_q <= 1'b0;
      end
      else
      begin
         if (s_start || s_done)
            bc_q <= 5'h00;
         else if (s_cap)
            bc_q <= bc_q + 5'h01;
         if (s_start)
            first_q <= pha;
         else if (s_done)
            first_q <= 1'b1;
         else if (s_chg)
            first_q <= 1'b0;
      end
   end

   // fifo handshakes, one cycle pulses
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_pop_q <= 1'b0;
         rx_write_q <= 1'b0;
         rx_data_q <= 16'h0000;
      end
      else
      begin
         tx_pop_q <= load && tx_valid;
         rx_write_q <= m_end || m_cont || s_done;
         if (m_end || m_cont)
            rx_data_q <= rx_word;
         else if (s_done)
            rx_data_q <= rx_next;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_clock_rests;
      (pins_q.clk == pol) [*2];
   endsequence

   sequence s_cmd_next_frame;
      !pins_q.fss && (pins_q.out == $past(tx_data[7])) && rx_write_q;
   endsequence

   a_idle_low_pins: assert property (state_q == ST_IDLE && $past(state_q == ST_IDLE)
      && en && $past(en) && master && !pol |-> !pins_q.clk && pins_q.fss && !pins_q.out)
      else $error("idle pins wrong with polarity zero");
   a_idle_high_pins: assert property (state_q == ST_IDLE && $past(state_q == ST_IDLE)
      && en && $past(en) && master && pol |-> pins_q.clk && pins_q.fss && !pins_q.out)
      else $error("idle pins wrong with polarity one");
   a_clock_driver: assert property (en && $past(en) && $past(en, 2)
      |-> pins_q.clk_oe == master)
      else $error("bit clock driver does not follow master setting");
   a_start_cause: assert property ($fell(pins_q.fss) |-> $past(tx_valid && en))
      else $error("frame started without data or enable");
   a_pha0_lead: assert property ($fell(pins_q.fss) && !is_cmd && !pha
      |-> s_clock_rests)
      else $error("clock moved too early in phase zero");
   a_pha1_lead: assert property ($fell(pins_q.fss) && !is_cmd && pha
      |-> pins_q.clk == pol)
      else $error("clock not idle when select fell");
   a_spi_word_end: assert property (m_end && en && !is_cmd
      |-> tc_q == n2 ##1 (pins_q.fss && rx_write_q))
      else $error("spi word length or select release wrong");
   a_pha0_gap: assert property (rx_write_q && !is_cmd && !pha && master
      && $past(state_q == ST_MASTER) |-> pins_q.fss)
      else $error("select not raised between phase zero words");
   a_pha1_hold: assert property (m_cont && !is_cmd
      |=> !pins_q.fss && rx_write_q)
      else $error("select released between phase one words");
   a_cmd_frame_len: assert property (m_end && en && is_cmd
      |-> tc_q == cmd_last + 6'h01 ##1 (pins_q.fss && rx_write_q))
      else $error("command frame length or end wrong");
   a_cmd_first_bit: assert property (m_start && is_cmd
      |=> !pins_q.fss && pins_q.out == $past(tx_data[7]))
      else $error("control msb not driven at select fall");
   a_cmd_back_to_back: assert property (m_cont && en && is_cmd
      |=> s_cmd_next_frame)
      else $error("continuous command frame broken");
   a_cfg_frozen: assert property (en && $past(en) |-> $stable(cfg_q))
      else $error("configuration changed while enabled");

endmodule // ssfs_seq

// ---- test/ssfs_peer.sv ----
`timescale 1ns/100ps
module ssfs_peer
   (
   // link as seen on the wires
   input wire logic bit_clk,
   input wire logic sel_b,
   input wire logic mosi,
   // behaviour chosen by the bench
   input wire logic cmd,
   input wire logic pha,
   input wire logic [4:0] n,
   input wire logic [15:0] word,
   // reply line and what was heard
   output logic sin,
   output logic [15:0] got,
   output logic [7:0] ctl
   );
   logic [15:0] sh;
   logic [15:0] mk;
   int e;
   initial sin = 1'b0;
   always @(negedge sel_b)
   begin
      e = 0;
      mk = 16'hffff >> (5'd16 - n);
      sh = word & mk;
      if (!cmd && !pha)
         sin = word[n - 1];
   end
   // no pull on the line: once released it shows the inverse
   always @(posedge sel_b) sin = ~sin;
   always @(bit_clk)
   begin
      if (sel_b === 1'b0 && cmd)
      begin
         // count rising edges per frame: 8 control, 1 wait, n reply
         if (bit_clk)
         begin
            e = (e == 9 + n) ? 1 : e + 1;
            if (e <= 8)
               ctl = {ctl[6:0], mosi};
         end
         else
            sin = (e >= 9 && e < 9 + n) ? word[n + 8 - e] : ~sin;
      end
      else if (sel_b === 1'b0)
      begin
         e = e + 1;
         if (e[0] != pha)
            got = {got[14:0], mosi};
         else
         begin
            // rotate so back-to-back words repeat without a reload
            if (e > 1)
               sh = ((sh << 1) | (sh >> (n - 1))) & mk;
            sin = sh[n - 1];
         end
      end
   end
endmodule // ssfs_peer

// ---- test/ssfs_seq_tb.sv ----
`timescale 1ns/100ps
`include "ssfs_cfg.svh"
module ssfs_seq_tb
   import ssfs_pkg::*;
   ;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata_q;
   logic tx_valid = 1'b0;
   logic [15:0] tx_data = 16'h0000;
   logic tx_pop_q;
   logic rx_write_q;
   logic [15:0] rx_data_q;
   ssfs_pins_type pins_q;
   logic m_clk = 1'b0;
   logic m_fss = 1'b1;
   logic m_sin = 1'b0;
   logic slv = 1'b0;
   logic p_cmd = 1'b0;
   logic p_pha = 1'b0;
   logic [4:0] p_n = 5'd8;
   logic [15:0] p_word = 16'h0000;
   logic p_sin;
   logic [15:0] p_got;
   logic [7:0] p_ctl;
   logic [15:0] exp_rx = 16'h0000;
   logic [15:0] rd_val;
   wire clk_w;
   wire fss_w;
   int bad_count = 0;
   int checked = 0;
   int pops = 0;
   int pushes = 0;
   int rises = 0;
   always #5 clk = ~clk;
   // two-way pins: port drives when enabled as master, else the bench master
   assign clk_w = pins_q.clk_oe ? pins_q.clk : m_clk;
   assign fss_w = pins_q.fss_oe ? pins_q.fss : m_fss;
   ssfs_seq i_dut
   (
      .clk(clk),
      .rst_b(rst_b),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q),
      .tx_valid(tx_valid),
      .tx_data(tx_data),
      .tx_pop_q(tx_pop_q),
      .rx_write_q(rx_write_q),
      .rx_data_q(rx_data_q),
      .bit_clock_line_i(clk_w),
      .frame_select_line_i(fss_w),
      .serial_in_line_i(slv ? m_sin : p_sin),
      .pins_q(pins_q)
   );
   ssfs_peer i_peer
   (
      .bit_clk(clk_w),
      .sel_b(fss_w),
      .mosi(pins_q.out),
      .cmd(p_cmd),
      .pha(p_pha),
      .n(p_n),
      .word(p_word),
      .sin(p_sin),
      .got(p_got),
      .ctl(p_ctl)
   );
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         bad_count++;
      end
   endtask
   always @(posedge clk)
   begin
      if (tx_pop_q === 1'b1)
         pops <= pops + 1;
      if (rx_write_q === 1'b1)
      begin
         pushes <= pushes + 1;
         chk("rx word", exp_rx, rx_data_q);
      end
   end
   always @(posedge fss_w) rises++;
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rd_val = reg_rdata_q;
   endtask
   task automatic wait_n(ref int cnt, input int want);
      for (int i = 0; i < 4000 && cnt < want; i++)
         @(negedge clk);
      if (cnt < want)
         chk("event count", 16'(want), 16'(cnt));
   endtask
   // two words with the fifo kept full until the second is taken
   task automatic run_pair(input logic [15:0] w);
      @(negedge clk);
      pops = 0;
      pushes = 0;
      rises = 0;
      @(posedge clk);
      tx_data <= w;
      tx_valid <= 1'b1;
      wait_n(pops, 2);
      @(posedge clk);
      tx_valid <= 1'b0;
      wait_n(pushes, 2);
      repeat (3) @(negedge clk);
   endtask
   task automatic t_regs();
      @(negedge clk);
      chk("reset pins", 16'h0008, {10'h000, pins_q});
      rd(`SSFS_ADDR_CTRL);
      chk("ctrl reset", 16'h0700, rd_val);
      rd(`SSFS_ADDR_DIV);
      chk("div reset", 16'h0004, rd_val);
      wr(8'h0c, 16'hffff);
      rd(8'h0c);
      chk("unmapped", 16'h0000, rd_val);
      wr(`SSFS_ADDR_DIV, 16'h0005);
      rd(`SSFS_ADDR_DIV);
      chk("div", 16'h0005, rd_val);
      rd(`SSFS_ADDR_STAT);
      chk("status idle", 16'h0002, rd_val);
      wr(`SSFS_ADDR_DIV, 16'h0004);
   endtask
   // bench is master at 125 ns, offset so no link edge meets clk
   task automatic t_slave();
      logic [15:0] got;
      got = 16'h0000;
      slv = 1'b1;
      wr(`SSFS_ADDR_CTRL, 16'h0703);
      @(negedge clk);
      pushes = 0;
      exp_rx = 16'h00d2;
      @(posedge clk);
      tx_data <= 16'h0069;
      tx_valid <= 1'b1;
      #1;
      m_fss = 1'b0;
      m_sin = exp_rx[7];
      #62.5;
      for (int i = 7; i >= 0; i--)
      begin
         m_clk = 1'b1;
         got = {got[14:0], pins_q.out};
         #62.5;
         m_clk = 1'b0;
         m_sin = (i > 0) ? exp_rx[i - 1] : ~m_sin;
         #62.5;
      end
      m_fss = 1'b1;
      wait_n(pushes, 1);
      chk("slave sent", 16'h0069, got);
      chk("slave clk drive", 16'h0000, {15'h0000, pins_q.clk_oe});
      chk("slave select drive", 16'h0000, {15'h0000, pins_q.fss_oe});
      @(posedge clk);
      tx_valid <= 1'b0;
      slv = 1'b0;
      wr(`SSFS_ADDR_CTRL, 16'h0000);
   endtask
   task automatic t_spi(input logic pol, input logic pha, input logic [4:0] n);
      logic [15:0] mk;
      mk = 16'hffff >> (5'd16 - n);
      p_cmd = 1'b0;
      p_pha = pha;
      p_n = n;
      p_word = 16'h9a5c;
      exp_rx = 16'h9a5c & mk;
      wr(`SSFS_ADDR_CTRL, {4'h0, 4'(n - 5'd1), 2'b00, pha, pol, 4'b0001});
      run_pair(16'h63a7);
      chk("select rises", pha ? 16'h0001 : 16'h0002, 16'(rises));
      chk("peer heard", 16'h63a7 & mk, p_got & mk);
      chk("idle pins", {12'h000, pol, 3'b110},
         {12'h000, pins_q.clk, pins_q.clk_oe, pins_q.fss, pins_q.out});
      chk("master drives", 16'h0003, {14'h0000, pins_q.fss_oe, pins_q.out_oe});
      wr(`SSFS_ADDR_CTRL, 16'h0000);
   endtask
   task automatic t_cmd();
      p_cmd = 1'b1;
      p_n = 5'd12;
      p_word = 16'h0a5c;
      exp_rx = 16'h0a5c;
      wr(`SSFS_ADDR_CTRL, 16'h0b05);
      run_pair(16'h00b7);
      chk("select rises", 16'h0001, 16'(rises));
      chk("control byte", 16'h00b7, {8'h00, p_ctl});
      chk("idle pins", 16'h0002, {13'h0000, pins_q.clk, pins_q.fss, pins_q.out});
      wr(`SSFS_ADDR_CTRL, 16'h0000);
   endtask
   // clearing enable mid-word must drop the word, not push it
   task automatic t_abort();
      wr(`SSFS_ADDR_CTRL, 16'h0701);
      @(negedge clk);
      pushes = 0;
      @(posedge clk);
      tx_valid <= 1'b1;
      repeat (20) @(posedge clk);
      tx_valid <= 1'b0;
      wr(`SSFS_ADDR_CTRL, 16'h0700);
      repeat (100) @(negedge clk);
      chk("aborted push", 16'h0000, 16'(pushes));
      chk("select after abort", 16'h0001, {15'h0000, pins_q.fss});
   endtask
   task automatic finish_test();
      if (bad_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_slave();
      t_spi(1'b0, 1'b0, 5'd4);
      t_spi(1'b0, 1'b1, 5'd8);
      t_spi(1'b1, 1'b0, 5'd13);
      t_spi(1'b1, 1'b1, 5'd16);
      t_cmd();
      t_abort();
      finish_test();
   end
   initial
   begin
      #200us;
      bad_count++;
      finish_test();
   end
endmodule // ssfs_seq_tb
